// ===== rtl/acs_section_logic.sv
// axle count section clear logic: sensor direction decode, redundant
// section counters, relay-style clear line chain and an AXI4-Lite slave.
// assumes sensor pins are asynchronous; the bus shares the system clock.
//
// Design decisions made here: the AXI4-Lite slave port and the address map.
`timescale 1ns/100ps
module acs_section_logic import acs_pkg::*; #(
    parameter int T1_SEC = T1_SECTIONS,
    parameter int T2_SEC = T2_SECTIONS,
    parameter int CNT_W = COUNT_W,
    parameter int FLASH_CYC = FLASH_CYCLES
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire acs_sensor_s [T1_SEC+T2_SEC+1:0] sensor_in,
    output logic [T1_SEC+T2_SEC-1:0] clear_line_open,
    output logic [T1_SEC+T2_SEC-1:0] occupied,
    output logic [T1_SEC+T2_SEC-1:0] minus_flash_a,
    output logic [T1_SEC+T2_SEC-1:0] minus_flash_b,
    output logic [T1_SEC+T2_SEC+1:0] sensor_breakdown,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    localparam int NSEC = T1_SEC + T2_SEC;
    localparam int NSEN = NSEC + 2; // each track has one sensor more than sections
    localparam logic [CNT_W-1:0] CNT_MAX = '1;
    localparam logic FIRST_AXLES_GATE = 1'b1; // suppression bypassed

    // --------------------------------------------------------------
    // state; zero everywhere is the idle, clear position
    // --------------------------------------------------------------
    typedef struct packed {
        logic [NSEN-1:0][2:0] sync1;
        logic [NSEN-1:0][2:0] sync2;
        acs_sen_e [NSEN-1:0] sen;
        logic [NSEN-1:0] ev_fwd;
        logic [NSEN-1:0] ev_rev;
        logic [NSEN-1:0] brk;
        logic [NSEC-1:0][CNT_W-1:0] cnt_a;
        logic [NSEC-1:0][CNT_W-1:0] cnt_b;
        logic [NSEC-1:0] minus;
        logic [NSEC-1:0] mismatch;
        logic [NSEC-1:0] rel_drop; // both release elements dropped
        logic [NSEC-1:0] clr_el_off;
        logic [NSEC-1:0] chold_off;
        logic [NSEC-1:0] oc_a;
        logic [NSEC-1:0] oc_b;
        logic [NSEC-1:0] oc3_drop;
        logic [NSEC-1:0] line_open;
        logic [NSEC-1:0] force_occ;
        logic [31:0] flash_cnt;
        logic flash_ph;
        logic [NSEC-1:0] fl_a;
        logic [NSEC-1:0] fl_b;
        logic aw_have;
        logic [7:0] awaddr;
        logic w_have;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } acs_state_s;

    acs_state_s q;
    acs_state_s d;

    // lower bounding sensor of a section; track two starts one sensor later
    function automatic int sec_lo(input int k);
        return (k < T1_SEC) ? k : k + 1;
    endfunction

    // status word of one section
    function automatic logic [31:0] sec_word(input acs_state_s s, input int k);
        logic [31:0] w;
        w = '0;
        w[ST_CNT_A_LSB +: CNT_W] = s.cnt_a[k];
        w[ST_CNT_B_LSB +: CNT_W] = s.cnt_b[k];
        w[ST_OCC_BIT] = s.oc_a[k] | s.oc_b[k];
        w[ST_LINE_OPEN_BIT] = s.line_open[k];
        w[ST_MINUS_BIT] = s.minus[k];
        w[ST_MISMATCH_BIT] = s.mismatch[k];
        w[ST_REL_DROP_BIT] = s.rel_drop[k];
        return w;
    endfunction

    // --------------------------------------------------------------
    // next state
    // --------------------------------------------------------------
    always_comb begin
        logic a;
        logic b;
        logic in_ev;
        logic out_ev;
        logic zero;
        logic sec_fault;
        logic [5:0] idx;
        int lo;
        int hi;
        a = 1'b0;
        b = 1'b0;
        in_ev = 1'b0;
        out_ev = 1'b0;
        zero = 1'b0;
        sec_fault = 1'b0;
        idx = '0;
        lo = 0;
        hi = 0;
        d = q;

        // two-flop synchronisers on every sensor pin
        d.sync1 = sensor_in;
        d.sync2 = q.sync1;

        // direction decode from the order of overlapping pulses
        d.ev_fwd = '0;
        d.ev_rev = '0;
        for (int s = 0; s < NSEN; s++) begin
            a = q.sync2[s][2];
            b = q.sync2[s][1];
            d.brk[s] = q.brk[s] | q.sync2[s][0]; // latched until reset
            case (q.sen[s])
                SEN_IDLE: begin
                    if (a && !b) d.sen[s] = SEN_FA;
                    else if (b && !a) d.sen[s] = SEN_RB;
                end
                SEN_FA: begin
                    if (a && b) d.sen[s] = SEN_FAB;
                    else if (!a) d.sen[s] = SEN_IDLE;
                end
                SEN_FAB: begin
                    if (!a && b) d.sen[s] = SEN_FB;
                    else if (a && !b) d.sen[s] = SEN_FA;
                    else if (!a) d.sen[s] = SEN_IDLE;
                end
                SEN_FB: begin
                    if (a && b) d.sen[s] = SEN_FAB;
                    else if (!b) begin
                        d.sen[s] = SEN_IDLE;
                        d.ev_fwd[s] = !a; // complete wheel toward higher index
                    end
                end
                SEN_RB: begin
                    if (a && b) d.sen[s] = SEN_RAB;
                    else if (!b) d.sen[s] = SEN_IDLE;
                end
                SEN_RAB: begin
                    if (a && !b) d.sen[s] = SEN_RA;
                    else if (b && !a) d.sen[s] = SEN_RB;
                    else if (!b) d.sen[s] = SEN_IDLE;
                end
                SEN_RA: begin
                    if (a && b) d.sen[s] = SEN_RAB;
                    else if (!a) begin
                        d.sen[s] = SEN_IDLE;
                        d.ev_rev[s] = !b; // complete wheel toward lower index
                    end
                end
                default: d.sen[s] = SEN_IDLE;
            endcase
        end

        // minus-axle flashing, the two channels alternate
        if (q.flash_cnt >= 32'(FLASH_CYC - 1)) begin
            d.flash_cnt = '0;
            d.flash_ph = !q.flash_ph;
        end else begin
            d.flash_cnt = q.flash_cnt + 32'h0000_0001;
        end

        // sections keep separate state; neighbours share the events and breakdown of their common sensor
        for (int k = 0; k < NSEC; k++) begin
            lo = sec_lo(k);
            hi = lo + 1;
            in_ev = q.ev_fwd[lo] | q.ev_rev[hi];
            out_ev = q.ev_rev[lo] | q.ev_fwd[hi];
            zero = (q.cnt_a[k] == '0) && (q.cnt_b[k] == '0);
            if (in_ev && !out_ev) begin
                if (q.cnt_a[k] != CNT_MAX) begin
                    d.cnt_a[k] = q.cnt_a[k] + CNT_W'(1);
                    d.cnt_b[k] = q.cnt_b[k] + CNT_W'(1);
                end
            end else if (out_ev && !in_ev) begin
                if (zero) begin
                    d.minus[k] = 1'b1; // more out than in
                end else begin
                    d.cnt_a[k] = q.cnt_a[k] - CNT_W'(1);
                    d.cnt_b[k] = q.cnt_b[k] - CNT_W'(1);
                end
            end
            d.mismatch[k] = q.mismatch[k] | (q.cnt_a[k] != q.cnt_b[k]);

            // direct pulse drops both release elements; re-energise at rest
            if (in_ev) d.rel_drop[k] = 1'b1;
            else if (zero && !q.minus[k]) d.rel_drop[k] = 1'b0;

            // counter outputs: occupied a/b, clear a/b as their inverse
            d.oc_a[k] = (q.cnt_a[k] != '0) | q.minus[k];
            d.oc_b[k] = ((q.cnt_b[k] != '0) & FIRST_AXLES_GATE) | q.minus[k];
            // clear element loses drive from release or counter clear outputs
            d.clr_el_off[k] = q.rel_drop[k] | q.oc_a[k] | q.oc_b[k];
            // clear-hold follows release change together with clear contact
            d.chold_off[k] = q.rel_drop[k] | (q.chold_off[k] & q.clr_el_off[k]);
            d.oc3_drop[k] = q.oc_a[k] | q.oc_b[k];

            sec_fault = q.mismatch[k] | q.brk[lo] | q.brk[hi];
            // series contacts; any one of them opens the line
            d.line_open[k] = q.clr_el_off[k] | q.chold_off[k] | q.oc3_drop[k]
                | sec_fault | q.force_occ[k];
            d.fl_a[k] = q.minus[k] & q.flash_ph;
            d.fl_b[k] = q.minus[k] & !q.flash_ph;
        end

        // ----------------------------------------------------------
        // AXI4-Lite write: address and data in either order
        // ----------------------------------------------------------
        if (s_axi_awvalid && q.awready) begin
            d.aw_have = 1'b1;
            d.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && q.wready) begin
            d.w_have = 1'b1;
            d.wdata = s_axi_wdata;
            d.wstrb = s_axi_wstrb;
        end
        if (q.bvalid && s_axi_bready) d.bvalid = 1'b0;
        if (q.aw_have && q.w_have && !q.bvalid) begin
            d.aw_have = 1'b0;
            d.w_have = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = RESP_OKAY;
            if (q.awaddr == FORCE_OCC_ADDR) begin
                if (q.wstrb[0]) d.force_occ = q.wdata[NSEC-1:0];
            end else if (q.awaddr == SENSOR_BRK_ADDR) begin
                d.bresp = RESP_OKAY; // read-only, write ignored
            end else if (q.awaddr < SEC_STAT_BASE + 8'(4 * NSEC)
                && q.awaddr[1:0] == 2'h0) begin
                d.bresp = RESP_OKAY; // read-only, write ignored
            end else begin
                d.bresp = RESP_SLVERR;
            end
        end
        d.awready = !d.aw_have && !d.bvalid;
        d.wready = !d.w_have && !d.bvalid;

        // ----------------------------------------------------------
        // AXI4-Lite read: one cycle from address to data
        // ----------------------------------------------------------
        if (q.rvalid && s_axi_rready) d.rvalid = 1'b0;
        if (s_axi_arvalid && q.arready) begin
            d.rvalid = 1'b1;
            d.rresp = RESP_OKAY;
            d.rdata = '0;
            idx = s_axi_araddr[ADDR_MSB:ADDR_LSB];
            if (s_axi_araddr == FORCE_OCC_ADDR) begin
                d.rdata[NSEC-1:0] = q.force_occ;
            end else if (s_axi_araddr == SENSOR_BRK_ADDR) begin
                d.rdata[NSEN-1:0] = q.brk;
            end else if (s_axi_araddr < SEC_STAT_BASE + 8'(4 * NSEC)
                && s_axi_araddr[1:0] == 2'h0) begin
                d.rdata = sec_word(q, int'(idx));
            end else begin
                d.rresp = RESP_SLVERR;
            end
        end
        d.arready = !d.rvalid;
    end

    // --------------------------------------------------------------
    // state register; all-zero reset is the idle clear position
    // --------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // outputs straight from the state register
    assign clear_line_open = q.line_open;
    assign occupied = q.oc3_drop;
    assign minus_flash_a = q.fl_a;
    assign minus_flash_b = q.fl_b;
    assign sensor_breakdown = q.brk;
    assign s_axi_awready = q.awready;
    assign s_axi_wready = q.wready;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_arready = q.arready;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;

endmodule // acs_section_logic

// ===== rtl/acs_pkg.sv
// package for the axle count section clear logic: register map, field
// layout, sensor carrier, track layout and timing constants.
// assumes one 100 MHz clock domain and an AXI4-Lite master on the same clock.
package acs_pkg;

    // --------------------------------------------------------------
    // track layout
    // --------------------------------------------------------------
    localparam int T1_SECTIONS = 3;
    localparam int T2_SECTIONS = 2;
    localparam int COUNT_W = 8;

    // --------------------------------------------------------------
    // register map, byte addresses
    // --------------------------------------------------------------
    localparam logic [7:0] SEC_STAT_BASE = 8'h00; // one word per section
    localparam logic [7:0] SENSOR_BRK_ADDR = 8'h20;
    localparam logic [7:0] FORCE_OCC_ADDR = 8'h24;
    localparam int ADDR_LSB = 2;
    localparam int ADDR_MSB = 7;

    // section status fields
    localparam int ST_CNT_A_LSB = 0;
    localparam int ST_CNT_B_LSB = 8;
    localparam int ST_OCC_BIT = 16;
    localparam int ST_LINE_OPEN_BIT = 17;
    localparam int ST_MINUS_BIT = 18;
    localparam int ST_MISMATCH_BIT = 19;
    localparam int ST_REL_DROP_BIT = 20;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // --------------------------------------------------------------
    // timing
    // --------------------------------------------------------------
    localparam int CLK_HZ = 100_000_000;
    localparam int FLASH_HALF_MS = 500; // minus-axle alternation half period
    localparam int FLASH_CYCLES = FLASH_HALF_MS * (CLK_HZ / 1000);

    // --------------------------------------------------------------
    // one double wheel sensor as seen at the pins
    // --------------------------------------------------------------
    typedef struct packed {
        logic sys_a; // first sensing system covered
        logic sys_b; // second sensing system covered
        logic fault; // cable open or short, or sensor off the rail
    } acs_sensor_s;

    // direction decode, gray along the forward wheel path only
    typedef enum logic [2:0] {
        SEN_IDLE = 3'h0,
        SEN_FA = 3'h1,
        SEN_FAB = 3'h3,
        SEN_FB = 3'h2,
        SEN_RB = 3'h6,
        SEN_RAB = 3'h7,
        SEN_RA = 3'h5
    } acs_sen_e;

endpackage

// ===== verif/acs_signal_proc.sv
// external signal processor model: reads each section's clear line only.
// assumes the line levels come straight from the section logic outputs.
`timescale 1ns/100ps
module acs_signal_proc #(
    parameter int N = 5
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [N-1:0] line_open,
    output logic [N-1:0] proceed_q
);
    // --------------------------------------------------------------
    // signal decision
    // --------------------------------------------------------------
    // a closed line is the only proceed cause; nothing else is looked at
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            proceed_q <= '0;
        end else begin
            proceed_q <= ~line_open;
        end
    end
endmodule // acs_signal_proc

// ===== verif/acs_section_logic_chk.sv
// checker for the axle count section logic, bound to its top ports.
// assumes one clock domain with a synchronous active low reset.
`timescale 1ns/100ps
module acs_section_logic_chk import acs_pkg::*; #(
    parameter int T1_SEC = T1_SECTIONS,
    parameter int T2_SEC = T2_SECTIONS
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire acs_sensor_s [T1_SEC+T2_SEC+1:0] sensor_in,
    input wire logic [T1_SEC+T2_SEC-1:0] clear_line_open,
    input wire logic [T1_SEC+T2_SEC-1:0] occupied,
    input wire logic [T1_SEC+T2_SEC-1:0] minus_flash_a,
    input wire logic [T1_SEC+T2_SEC-1:0] minus_flash_b,
    input wire logic [T1_SEC+T2_SEC+1:0] sensor_breakdown,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    // --------------------------------------------------------------
    // bus sequences
    // --------------------------------------------------------------
    sequence s_read_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence s_read_answer;
        s_axi_rvalid && !s_axi_arready;
    endsequence

    chk_idle_start: assert property ($rose(rst_n) |-> clear_line_open == '0 && occupied == '0)
        else $error("outputs not idle after reset");
    chk_read_latency: assert property (s_read_take |=> s_read_answer)
        else $error("read answer late");
    chk_read_err_zero: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == '0)
        else $error("error read carries data");
    chk_bvalid_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    chk_brk_line: assert property (sensor_breakdown[5] |-> ##[0:3] clear_line_open[4:3] == 2'b11)
        else $error("breakdown left line closed");

    // --------------------------------------------------------------
    // per section and per sensor rules
    // --------------------------------------------------------------
    for (genvar i = 0; i < T1_SEC + T2_SEC; i++) begin : g_sec
        chk_occ_opens: assert property (occupied[i] |-> ##[0:3] clear_line_open[i])
            else $error("occupied section with closed line");
        chk_close_clear: assert property ($fell(clear_line_open[i]) |-> !occupied[i])
            else $error("line closed while occupied");
        chk_minus_held: assert property (minus_flash_a[i] || minus_flash_b[i] |->
            ##[0:3] clear_line_open[i] && occupied[i])
            else $error("minus state not held occupied");
        chk_minus_latch: assert property (minus_flash_a[i] || minus_flash_b[i] |=>
            minus_flash_a[i] || minus_flash_b[i])
            else $error("minus indication dropped");
        chk_minus_alt: assert property (!(minus_flash_a[i] && minus_flash_b[i]))
            else $error("minus lamps not alternating");
    end
    for (genvar j = 0; j < T1_SEC + T2_SEC + 2; j++) begin : g_sen
        chk_fault_brk: assert property (sensor_in[j].fault |-> ##[1:5] sensor_breakdown[j])
            else $error("sensor fault not reported");
        chk_brk_latch: assert property (sensor_breakdown[j] |=> sensor_breakdown[j])
            else $error("breakdown released before reset");
    end
endmodule // acs_section_logic_chk

bind acs_section_logic acs_section_logic_chk #(.T1_SEC(T1_SEC), .T2_SEC(T2_SEC)) chk_inst (
    .clock(clock), .rst_n(rst_n), .sensor_in(sensor_in), .clear_line_open(clear_line_open),
    .occupied(occupied), .minus_flash_a(minus_flash_a), .minus_flash_b(minus_flash_b),
    .sensor_breakdown(sensor_breakdown), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid));

// ===== verif/acs_section_logic_tb_top.sv
// testbench for the axle count section logic: wheel passes, faults, bus.
// assumes the checker is bound in and the flash half period is shortened to 8 cycles.
`timescale 1ns/100ps
module acs_section_logic_tb_top import acs_pkg::*;;
    logic clock = 0, rst_n = 0;
    acs_sensor_s [6:0] sensor_in = '0;
    logic [4:0] line, occ, fl_a, fl_b, proceed;
    logic [6:0] brk;
    logic [7:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata, rd;
    logic [3:0] wstrb = '0;
    logic [1:0] bresp, rresp, rsp;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid;
    int n_errors = 0, check_count = 0;

    always #5 clock = ~clock;

    acs_section_logic #(.FLASH_CYC(8)) acs_section_logic_inst (.clock(clock), .rst_n(rst_n),
        .sensor_in(sensor_in), .clear_line_open(line), .occupied(occ), .minus_flash_a(fl_a),
        .minus_flash_b(fl_b), .sensor_breakdown(brk), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    acs_signal_proc #(.N(5)) acs_signal_proc_inst (.clock(clock), .rst_n(rst_n),
        .line_open(line), .proceed_q(proceed));

    // --------------------------------------------------------------
    // shared tasks
    // --------------------------------------------------------------
    task automatic stop_test();
        if (n_errors == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // ready is sampled at the falling edge, which equals its value at the next rising edge
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        bit aw_h, w_h, b_h;
        @(posedge clock);
        awaddr <= a; wdata <= d; wstrb <= 4'hf; awvalid <= 1; wvalid <= 1; bready <= 1;
        b_h = 0;
        for (int n = 0; n < 50 && !b_h; n++) begin
            @(negedge clock);
            aw_h = awvalid && awready; w_h = wvalid && wready; b_h = bvalid; rsp = bresp;
            @(posedge clock);
            if (aw_h) awvalid <= 0;
            if (w_h) wvalid <= 0;
            if (b_h) bready <= 0;
        end
        if (!b_h) begin n_errors++; stop_test(); end
        chk("bresp", {30'h0, er}, {30'h0, rsp});
    endtask
    task automatic axi_read(input logic [7:0] a, input logic [1:0] er);
        bit ar_h, r_h;
        @(posedge clock);
        araddr <= a; arvalid <= 1; rready <= 1;
        r_h = 0;
        for (int n = 0; n < 50 && !r_h; n++) begin
            @(negedge clock);
            ar_h = arvalid && arready; r_h = rvalid; rd = rdata; rsp = rresp;
            @(posedge clock);
            if (ar_h) arvalid <= 0;
            if (r_h) rready <= 0;
        end
        if (!r_h) begin n_errors++; stop_test(); end
        chk("rresp", {30'h0, er}, {30'h0, rsp});
    endtask
    // one wheel over sensor s; forward covers a, both, b, none
    task automatic wheel(input int s, input bit fwd);
        logic [3:0] pa, pb;
        pa = fwd ? 4'b0011 : 4'b0110;
        pb = fwd ? 4'b0110 : 4'b0011;
        for (int i = 0; i < 4; i++) begin
            @(posedge clock);
            sensor_in[s].sys_a <= pa[i];
            sensor_in[s].sys_b <= pb[i];
            repeat (3) @(posedge clock);
        end
    endtask
    // looks only at falling edges so the line is settled; a timeout ends the run
    task automatic wait_line(input int k, input logic v);
        int n;
        @(negedge clock);
        for (n = 0; n < 40 && line[k] !== v; n++) @(negedge clock);
        chk("clear line", {31'h0, v}, {31'h0, line[k]});
        if (line[k] !== v) stop_test();
    endtask
    // expected status word for a settled section
    task automatic stat(input int k, input logic [7:0] c, input logic op);
        axi_read(8'(4 * k), RESP_OKAY);
        chk("status", {12'h0, 2'b00, op, c != 0, c, c}, {12'h0, rd[19:0]});
    endtask
    task automatic do_reset();
        @(posedge clock);
        rst_n <= 0;
        repeat (2) @(posedge clock);
        rst_n <= 1;
        repeat (4) @(posedge clock);
        @(negedge clock);
        chk("idle", 32'h0, {line, occ, fl_a, fl_b, brk});
    endtask

    // --------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------
    initial begin
        do_reset();
        stat(0, 8'd0, 0);
        // a train runs forward through all of track one
        wheel(0, 1); wait_line(0, 1);
        stat(0, 8'd1, 1);
        chk("occupied", 32'h1, {27'h0, occ});
        wheel(1, 1); wait_line(1, 1); wait_line(0, 0);
        stat(0, 8'd0, 0);
        stat(1, 8'd1, 1);
        wheel(2, 1); wait_line(2, 1);
        wheel(3, 1); wait_line(2, 0);
        // track two run in reverse
        wheel(6, 0); wait_line(4, 1);
        stat(4, 8'd1, 1);
        wheel(5, 0); wait_line(3, 1); wait_line(4, 0);
        wheel(4, 0); wait_line(3, 0);
        @(negedge clock);
        chk("proceed", 32'h1f, {27'h0, proceed});
        // two axles in, three out: minus axle state
        wheel(0, 1); wheel(0, 1);
        stat(0, 8'd2, 1);
        repeat (3) wheel(0, 0);
        repeat (6) @(posedge clock);
        axi_read(8'h00, RESP_OKAY);
        chk("minus", 32'h7_0000, rd & 32'h7_0000);
        chk("flash", 32'h1, {31'h0, fl_a[0] ^ fl_b[0]});
        // a reverse wheel at sensor 1 would leave section 1, so re-cross sensor 0
        wheel(0, 1);
        wheel(0, 0);
        chk("minus line", 32'h1, {31'h0, line[0]});
        // sensor fault between the two track two sections
        @(posedge clock); sensor_in[5].fault <= 1;
        repeat (4) @(posedge clock); sensor_in[5].fault <= 0;
        wait_line(3, 1); wait_line(4, 1);
        axi_read(8'h20, RESP_OKAY);
        chk("breakdown", 32'h20, rd & 32'h7f);
        // register access: force, ignored status write, unmapped places
        axi_write(8'h24, 32'h0000_0004, RESP_OKAY);
        wait_line(2, 1);
        axi_read(8'h24, RESP_OKAY);
        chk("force reg", 32'h4, rd & 32'h1f);
        axi_write(8'h04, 32'h0000_00ff, RESP_OKAY);
        stat(1, 8'd0, 0);
        axi_read(8'h40, RESP_SLVERR);
        chk("unmapped data", 32'h0, rd);
        axi_write(8'h41, 32'h0000_0001, RESP_SLVERR);
        do_reset();
        stop_test();
    end
endmodule // acs_section_logic_tb_top
